// file: core/autoneg_pkg.sv
// Package: offsets, field positions, reset values and carriers for the ability registers
package autoneg_pkg;

  // ----------------------------------------------------------------
  // Register addresses (register index on the management bus)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_ADVERT    = 5'h04;
  localparam logic [4:0] ADDR_PARTNER   = 5'h05;
  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_NP_TX     = 5'h07;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_NEXT_PAGE   = 15;
  localparam int BIT_ACK         = 14;
  localparam int BIT_RF_HI       = 13;
  localparam int BIT_RF_LO       = 12;
  localparam int BIT_PAUSE_HI    = 8;
  localparam int BIT_PAUSE_LO    = 7;
  localparam int BIT_HALF_DUPLEX = 6;
  localparam int BIT_FULL_DUPLEX = 5;
  localparam int BIT_NP_ABLE     = 2;
  localparam int BIT_PAGE_RX     = 1;
  localparam int BIT_MSG_PAGE    = 13;
  localparam int BIT_ACK2        = 12;
  localparam int BIT_TOGGLE      = 11;
  localparam int CODE_HI         = 10;

  // ----------------------------------------------------------------
  // Writable masks, partner field mask and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ADVERT_WMASK = 16'h31a0;
  localparam logic [15:0] ADVERT_RESET = 16'h01a0;
  localparam logic [15:0] PARTNER_MASK = 16'hf1e0;
  localparam logic [15:0] NP_TX_WMASK  = 16'hb7ff;
  localparam logic [15:0] NP_TX_RESET  = 16'h2001;

  // Remote fault codes
  localparam logic [1:0] RF_NO_ERROR = 2'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic        page_valid;
    logic [15:0] page;
    logic        complete;
    logic        np_sent;
  } neg_event_t;

endpackage : autoneg_pkg

// file: core/autoneg_ability_registers.sv
// Auto-negotiation ability, expansion and next-page transmit register bank
//
// Overview of operation
// - Advertised next-page bit ignores writes and always reads 0.
// - Advertised pause field writable, resets to 11.
// - Advertised half-duplex bit reads 0, writes ignored.
// - Advertised full-duplex bit writable, resets to 1.
// - Advertisement reserved bits read zero, writes discarded.
// - Partner register read-only, received fields, resets to zero.
// - Partner acknowledge bit read-only, set by negotiation logic.
// - Page-received flag sets on new page, clears on expansion read.
// - Expansion next-page-able bit reads 1, no effect.
// - Transmit next-page bit writable, resets to 0.
// - Transmit acknowledge-2 bit writable, resets to 0.
// - Transmit toggle read-only, alternates per transmitted next page.
// - Transmit code field writable, resets to null message code.
// - Advertisement also loadable from configuration port.
// - Any core reset, software reset too, restores all defaults.
`timescale 1ns/1ns
`default_nettype none

module autoneg_ability_registers (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire logic                    soft_reset,
  input  wire autoneg_pkg::mgmt_req_t  mgmt_req,
  output logic [15:0]                  mgmt_rdata,
  input  wire logic                    config_valid,
  input  wire logic [15:0]             config_advert,
  input  wire autoneg_pkg::neg_event_t neg_event,
  output logic [15:0]                  advert_out,
  output logic [15:0]                  np_tx_out,
  output logic                         page_received
);
  import autoneg_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic sel_advert = mgmt_req.addr == ADDR_ADVERT;
  wire logic sel_exp    = mgmt_req.addr == ADDR_EXPANSION;
  wire logic sel_np     = mgmt_req.addr == ADDR_NP_TX;
  wire logic sel_part   = mgmt_req.addr == ADDR_PARTNER;
  wire logic wr_advert  = mgmt_req.wr_en && sel_advert;
  wire logic wr_np      = mgmt_req.wr_en && sel_np;
  wire logic rd_exp     = mgmt_req.rd_en && sel_exp;

  logic [15:0] advert_q, advert_d;
  logic [15:0] partner_q, partner_d;
  logic        page_rx_q, page_rx_d;
  logic [15:0] np_tx_q, np_tx_d;
  logic        toggle_q, toggle_d;

  // ----------------------------------------------------------------
  // Advertisement next value
  // ----------------------------------------------------------------
  // Bus write wins over the configuration port when both strike together
  wire logic [15:0] adv_src = wr_advert ? mgmt_req.wdata : config_advert;
  wire logic        adv_ld  = wr_advert || config_valid;
  // Masking keeps next page, half duplex and reserved bits at 0
  wire logic [15:0] adv_new = adv_ld ? (adv_src & ADVERT_WMASK) : advert_q;

  always_comb begin
    advert_d = adv_new;
    if (neg_event.complete) begin
      advert_d[BIT_RF_HI:BIT_RF_LO] = RF_NO_ERROR;
    end
  end

  // ----------------------------------------------------------------
  // Partner, expansion and next-page transmit next values
  // ----------------------------------------------------------------
  assign partner_d = neg_event.page_valid ? (neg_event.page & PARTNER_MASK) : partner_q;
  // Set wins over read-clear so a page landing on the read is not lost
  assign page_rx_d = neg_event.page_valid | (page_rx_q & ~rd_exp);
  assign np_tx_d   = wr_np ? (mgmt_req.wdata & NP_TX_WMASK) : np_tx_q;
  assign toggle_d  = neg_event.np_sent ? ~toggle_q : toggle_q;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      advert_q  <= ADVERT_RESET;
      partner_q <= 16'h0000;
      page_rx_q <= 1'b0;
      np_tx_q   <= NP_TX_RESET;
      toggle_q  <= 1'b0;
    end else if (soft_reset) begin
      advert_q  <= ADVERT_RESET;
      partner_q <= 16'h0000;
      page_rx_q <= 1'b0;
      np_tx_q   <= NP_TX_RESET;
      toggle_q  <= 1'b0;
    end else begin
      advert_q  <= advert_d;
      partner_q <= partner_d;
      page_rx_q <= page_rx_d;
      np_tx_q   <= np_tx_d;
      toggle_q  <= toggle_d;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire logic [15:0] exp_view = {13'h0000, 1'b1, page_rx_q, 1'b0};
  wire logic [15:0] np_view  = {np_tx_q[15:12], toggle_q, np_tx_q[CODE_HI:0]};

  // Unmapped addresses read zero; read data is combinational off registers
  assign mgmt_rdata = sel_advert ? advert_q  :
                      sel_part   ? partner_q :
                      sel_exp    ? exp_view  :
                      sel_np     ? np_view   : 16'h0000;

  assign advert_out    = advert_q;
  assign np_tx_out     = np_view;
  assign page_received = page_rx_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_np_zero;
    @(posedge clock) disable iff (reset) !advert_q[BIT_NEXT_PAGE];
  endproperty
  a_np_zero: assert property (p_np_zero) else $error("advert next page set");

  property p_rf_clear;
    @(posedge clock) disable iff (reset)
      neg_event.complete |=> advert_q[BIT_RF_HI:BIT_RF_LO] == RF_NO_ERROR;
  endproperty
  a_rf_clear: assert property (p_rf_clear) else $error("remote fault not cleared");

  property p_half_zero;
    @(posedge clock) disable iff (reset) !advert_q[BIT_HALF_DUPLEX] && (advert_q & ~ADVERT_WMASK) == 16'h0000;
  endproperty
  a_half_zero: assert property (p_half_zero) else $error("advert fixed bits nonzero");

  property p_adv_write;
    @(posedge clock) disable iff (reset)
      wr_advert && !neg_event.complete && !soft_reset |=>
        advert_q[BIT_PAUSE_HI:BIT_PAUSE_LO] == $past(mgmt_req.wdata[BIT_PAUSE_HI:BIT_PAUSE_LO]);
  endproperty
  a_adv_write: assert property (p_adv_write) else $error("pause write lost");

  property p_page_set;
    @(posedge clock) disable iff (reset)
      neg_event.page_valid && !soft_reset |=>
        page_rx_q ##1 (page_rx_q || $past(rd_exp) || $past(soft_reset));
  endproperty
  a_page_set: assert property (p_page_set) else $error("page flag not set");

  property p_page_clr;
    @(posedge clock) disable iff (reset)
      rd_exp && !neg_event.page_valid |=> !page_rx_q;
  endproperty
  a_page_clr: assert property (p_page_clr) else $error("page flag not cleared");

  property p_toggle;
    @(posedge clock) disable iff (reset)
      neg_event.np_sent && !soft_reset |=> toggle_q != $past(toggle_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not flip");

  property p_soft;
    @(posedge clock) disable iff (reset)
      soft_reset |=> advert_q == ADVERT_RESET && np_tx_q == NP_TX_RESET && partner_q == 16'h0000;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left state");

  property p_exp_view;
    @(posedge clock) disable iff (reset)
      sel_exp |-> mgmt_rdata[BIT_NP_ABLE] && mgmt_rdata[15:3] == 13'h0000 && !mgmt_rdata[0];
  endproperty
  a_exp_view: assert property (p_exp_view) else $error("expansion fixed bits wrong");

  property p_partner_ro;
    @(posedge clock) disable iff (reset)
      !neg_event.page_valid && !soft_reset |=> partner_q == $past(partner_q);
  endproperty
  a_partner_ro: assert property (p_partner_ro) else $error("partner changed without page");

  property p_adv_hold;
    @(posedge clock) disable iff (reset)
      !wr_advert && !config_valid && !neg_event.complete && !soft_reset |=> advert_q == $past(advert_q);
  endproperty
  a_adv_hold: assert property (p_adv_hold) else $error("advert changed unasked");

  property p_adv_fd;
    @(posedge clock) disable iff (reset)
      wr_advert && !soft_reset |=> advert_q[BIT_FULL_DUPLEX] == $past(mgmt_req.wdata[BIT_FULL_DUPLEX]);
  endproperty
  a_adv_fd: assert property (p_adv_fd) else $error("full duplex write lost");

  property p_adv_rf_wr;
    @(posedge clock) disable iff (reset)
      wr_advert && !neg_event.complete && !soft_reset |=>
        advert_q[BIT_RF_HI:BIT_RF_LO] == $past(mgmt_req.wdata[BIT_RF_HI:BIT_RF_LO]);
  endproperty
  a_adv_rf_wr: assert property (p_adv_rf_wr) else $error("remote fault write lost");

  property p_adv_cfg;
    @(posedge clock) disable iff (reset)
      config_valid && !wr_advert && !soft_reset |=>
        advert_q[BIT_PAUSE_HI:BIT_PAUSE_LO] == $past(config_advert[BIT_PAUSE_HI:BIT_PAUSE_LO]);
  endproperty
  a_adv_cfg: assert property (p_adv_cfg) else $error("config pause load lost");

  property p_adv_cfg_fd;
    @(posedge clock) disable iff (reset)
      config_valid && !wr_advert && !soft_reset |=>
        advert_q[BIT_FULL_DUPLEX] == $past(config_advert[BIT_FULL_DUPLEX]);
  endproperty
  a_adv_cfg_fd: assert property (p_adv_cfg_fd) else $error("config duplex load lost");

  property p_adv_bus_wins;
    @(posedge clock) disable iff (reset)
      wr_advert && config_valid && !soft_reset |=>
        advert_q[BIT_PAUSE_HI:BIT_PAUSE_LO] == $past(mgmt_req.wdata[BIT_PAUSE_HI:BIT_PAUSE_LO]);
  endproperty
  a_adv_bus_wins: assert property (p_adv_bus_wins) else $error("config beat bus write");

  property p_adv_rsv_hi;
    @(posedge clock) disable iff (reset)
      !advert_q[BIT_ACK] && advert_q[11:9] == 3'h0;
  endproperty
  a_adv_rsv_hi: assert property (p_adv_rsv_hi) else $error("advert upper reserved set");

  property p_adv_rsv_lo;
    @(posedge clock) disable iff (reset)
      advert_q[4:0] == 5'h00;
  endproperty
  a_adv_rsv_lo: assert property (p_adv_rsv_lo) else $error("advert lower reserved set");

  property p_adv_np_wr;
    @(posedge clock) disable iff (reset)
      wr_advert && mgmt_req.wdata[BIT_NEXT_PAGE] |=> !advert_q[BIT_NEXT_PAGE];
  endproperty
  a_adv_np_wr: assert property (p_adv_np_wr) else $error("next page write taken");

  property p_half_wr;
    @(posedge clock) disable iff (reset)
      wr_advert && mgmt_req.wdata[BIT_HALF_DUPLEX] |=> !advert_q[BIT_HALF_DUPLEX];
  endproperty
  a_half_wr: assert property (p_half_wr) else $error("half duplex write taken");

  property p_partner_load;
    @(posedge clock) disable iff (reset)
      neg_event.page_valid && !soft_reset |=> partner_q == ($past(neg_event.page) & PARTNER_MASK);
  endproperty
  a_partner_load: assert property (p_partner_load) else $error("partner page not stored");

  property p_partner_ack;
    @(posedge clock) disable iff (reset)
      neg_event.page_valid && !soft_reset |=> partner_q[BIT_ACK] == $past(neg_event.page[BIT_ACK]);
  endproperty
  a_partner_ack: assert property (p_partner_ack) else $error("partner ack not stored");

  property p_partner_rsv;
    @(posedge clock) disable iff (reset)
      (partner_q & ~PARTNER_MASK) == 16'h0000;
  endproperty
  a_partner_rsv: assert property (p_partner_rsv) else $error("partner reserved set");

  property p_partner_wr;
    @(posedge clock) disable iff (reset)
      mgmt_req.wr_en && sel_part && !neg_event.page_valid && !soft_reset |=> $stable(partner_q);
  endproperty
  a_partner_wr: assert property (p_partner_wr) else $error("partner took a bus write");

  property p_page_hold;
    @(posedge clock) disable iff (reset)
      !neg_event.page_valid && !rd_exp && !soft_reset |=> page_rx_q == $past(page_rx_q);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page flag moved unasked");

  property p_page_other_rd;
    @(posedge clock) disable iff (reset)
      mgmt_req.rd_en && !sel_exp && page_rx_q && !soft_reset |=> page_rx_q;
  endproperty
  a_page_other_rd: assert property (p_page_other_rd) else $error("page flag cleared by other read");

  property p_page_soft;
    @(posedge clock) disable iff (reset)
      soft_reset |=> !page_rx_q && !toggle_q;
  endproperty
  a_page_soft: assert property (p_page_soft) else $error("soft reset left flags");

  property p_exp_rd;
    @(posedge clock) disable iff (reset)
      sel_exp |-> mgmt_rdata[BIT_PAGE_RX] == page_rx_q;
  endproperty
  a_exp_rd: assert property (p_exp_rd) else $error("expansion page bit wrong");

  property p_np_hold;
    @(posedge clock) disable iff (reset)
      !wr_np && !soft_reset |=> np_tx_q == $past(np_tx_q);
  endproperty
  a_np_hold: assert property (p_np_hold) else $error("transmit page changed unasked");

  property p_np_next;
    @(posedge clock) disable iff (reset)
      wr_np && !soft_reset |=> np_tx_q[BIT_NEXT_PAGE] == $past(mgmt_req.wdata[BIT_NEXT_PAGE]);
  endproperty
  a_np_next: assert property (p_np_next) else $error("transmit next page lost");

  property p_np_msg;
    @(posedge clock) disable iff (reset)
      wr_np && !soft_reset |=> np_tx_q[BIT_MSG_PAGE] == $past(mgmt_req.wdata[BIT_MSG_PAGE]);
  endproperty
  a_np_msg: assert property (p_np_msg) else $error("message page write lost");

  property p_np_ack2;
    @(posedge clock) disable iff (reset)
      wr_np && !soft_reset |=> np_tx_q[BIT_ACK2] == $past(mgmt_req.wdata[BIT_ACK2]);
  endproperty
  a_np_ack2: assert property (p_np_ack2) else $error("acknowledge 2 write lost");

  property p_np_code;
    @(posedge clock) disable iff (reset)
      wr_np && !soft_reset |=> np_tx_q[CODE_HI:0] == $past(mgmt_req.wdata[CODE_HI:0]);
  endproperty
  a_np_code: assert property (p_np_code) else $error("code field write lost");

  property p_toggle_wr;
    @(posedge clock) disable iff (reset)
      wr_np && !neg_event.np_sent && !soft_reset |=> toggle_q == $past(toggle_q);
  endproperty
  a_toggle_wr: assert property (p_toggle_wr) else $error("toggle took a bus write");

  property p_toggle_hold;
    @(posedge clock) disable iff (reset)
      !neg_event.np_sent && !soft_reset |=> toggle_q == $past(toggle_q);
  endproperty
  a_toggle_hold: assert property (p_toggle_hold) else $error("toggle moved unasked");

  property p_np_rsv;
    @(posedge clock) disable iff (reset)
      !np_tx_out[14];
  endproperty
  a_np_rsv: assert property (p_np_rsv) else $error("transmit reserved bit set");

endmodule : autoneg_ability_registers

`default_nettype wire

// file: tb/neg_partner.sv
// Negotiation-side model: raises page, completion, next-page and configuration pulses
`timescale 1ns/1ns
`default_nettype none

module neg_partner (
  input  wire logic               clock,
  output autoneg_pkg::neg_event_t ev,
  output logic                    cfg_valid,
  output logic [15:0]             cfg_data
);
  import autoneg_pkg::*;

  initial begin
    ev        = '0;
    cfg_valid = 1'b0;
    cfg_data  = 16'h0000;
  end

  // -----------------------------------------------------------------
  // One-cycle pulse launched just after an edge
  // -----------------------------------------------------------------
  // Stale data is inverted on release so a late sample cannot match
  task automatic pulse(input neg_event_t e, input logic c, input logic [15:0] d);
    @(posedge clock);
    #1;
    ev        = e;
    cfg_valid = c;
    cfg_data  = d;
    @(posedge clock);
    #1;
    ev        = '0;
    ev.page   = ~e.page;
    cfg_valid = 1'b0;
    cfg_data  = ~d;
  endtask : pulse
endmodule : neg_partner

`default_nettype wire

// file: tb/autoneg_ability_registers_tb.sv
// Testbench: management reads and writes against the ability register bank
`timescale 1ns/1ns
`default_nettype none

module autoneg_ability_registers_tb;
  import autoneg_pkg::*;

  logic        clock;
  logic        reset;
  logic        soft_reset;
  mgmt_req_t   req;
  neg_event_t  ev;
  logic        cfg_valid;
  logic [15:0] cfg_data;
  logic [15:0] mgmt_rdata;
  logic [15:0] advert_out;
  logic [15:0] np_tx_out;
  logic        page_received;
  int          failures = 0;
  int          checked = 0;

  autoneg_ability_registers dut (.clock(clock), .reset(reset), .soft_reset(soft_reset),
    .mgmt_req(req), .mgmt_rdata(mgmt_rdata), .config_valid(cfg_valid),
    .config_advert(cfg_data), .neg_event(ev), .advert_out(advert_out),
    .np_tx_out(np_tx_out), .page_received(page_received));
  neg_partner p (.clock(clock), .ev(ev), .cfg_valid(cfg_valid), .cfg_data(cfg_data));

  // -----------------------------------------------------------------
  // Access tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    req = '{1'b1, 1'b0, a, d};
    @(posedge clock);
    #1;
    req = '0;
  endtask : wr

  // Read data is combinational, so it is sampled before the taking edge
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clock);
    #1;
    req = '{1'b0, 1'b1, a, 16'h0000};
    #10;
    chk(mgmt_rdata, exp);
    @(posedge clock);
    #1;
    req = '0;
  endtask : rd

  task automatic defaults;
    rd(ADDR_ADVERT, ADVERT_RESET);
    rd(ADDR_PARTNER, 16'h0000);
    rd(ADDR_EXPANSION, 16'h0004);
    rd(ADDR_NP_TX, NP_TX_RESET);
    chk({15'h0000, page_received}, 16'h0000);
  endtask : defaults

  task automatic final_report;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // -----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // -----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (4000) @(posedge clock);
    failures++;
    final_report;
  end

  initial begin
    req = '0;
    soft_reset = 1'b0;
    reset = 1'b1;
    repeat (10) @(posedge clock);
    #1 reset = 1'b0;
    defaults;
    wr(ADDR_ADVERT, 16'hffff);
    rd(ADDR_ADVERT, ADVERT_WMASK);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_ADVERT, {2'h0, i[1:0], 3'h0, i[1:0], 1'b0, i[0], 5'h00});
      rd(ADDR_ADVERT, {2'h0, i[1:0], 3'h0, i[1:0], 1'b0, i[0], 5'h00});
    end
    p.pulse('{1'b0, 16'h0000, 1'b1, 1'b0}, 1'b0, 16'h0000);
    rd(ADDR_ADVERT, 16'h01a0);
    p.pulse('{1'b1, 16'hffff, 1'b0, 1'b0}, 1'b0, 16'h0000);
    chk({15'h0000, page_received}, 16'h0001);
    rd(ADDR_PARTNER, PARTNER_MASK);
    wr(ADDR_PARTNER, 16'h0000);
    rd(ADDR_PARTNER, PARTNER_MASK);
    rd(ADDR_EXPANSION, 16'h0006);
    rd(ADDR_EXPANSION, 16'h0004);
    wr(ADDR_NP_TX, 16'hffff);
    rd(ADDR_NP_TX, NP_TX_WMASK);
    p.pulse('{1'b0, 16'h0000, 1'b0, 1'b1}, 1'b0, 16'h0000);
    chk(np_tx_out, 16'hbfff);
    p.pulse('{1'b0, 16'h0000, 1'b0, 1'b1}, 1'b0, 16'h0000);
    rd(ADDR_NP_TX, NP_TX_WMASK);
    p.pulse('{1'b0, 16'h0000, 1'b0, 1'b0}, 1'b1, 16'hffff);
    chk(advert_out, ADVERT_WMASK);
    rd(5'h1f, 16'h0000);
    p.pulse('{1'b1, 16'h5a5a, 1'b0, 1'b1}, 1'b0, 16'h0000);
    @(posedge clock);
    #1 soft_reset = 1'b1;
    @(posedge clock);
    #1 soft_reset = 1'b0;
    defaults;
    wr(ADDR_NP_TX, 16'h0000);
    p.pulse('{1'b1, 16'hffff, 1'b0, 1'b1}, 1'b0, 16'h0000);
    @(posedge clock);
    #1 reset = 1'b1;
    repeat (2) @(posedge clock);
    #1 reset = 1'b0;
    defaults;
    final_report;
  end
endmodule : autoneg_ability_registers_tb

`default_nettype wire
